// file: src/psmp_paper_sense_ctrl.sv
// The address-and-strobe port was decided locally.
`include "psmp_params.svh"

// ============================================================
module psmp_paper_sense_ctrl #(
    parameter int TRAVEL_W    = 12,
    parameter int SYNC_STAGES = 2
) (
    // Clock and reset
    input  wire logic                    ref_clk_in,
    input  wire logic                    sys_rst_in,
    // Register bus
    input  wire psmp_pkg::psmp_bus_req_t bus_req_in,
    output logic [31:0]                  bus_rdata_out,
    // Paper detect inputs
    input  wire logic                    paper_detect_in_a,
    input  wire logic                    paper_detect_in_b,
    // General pin
    input  wire logic                    gpio_pin_in,
    output logic                         gpio_pin_out,
    output logic                         gpio_pin_oe_out,
    // System
    input  wire logic                    bus_suspend_in,
    input  wire logic                    full_step_in,
    output logic                         scan_active_out,
    output logic                         irq_out
);
    import psmp_pkg::*;

    generate
        if (TRAVEL_W < 1 || TRAVEL_W > 16) begin : g_chk
            $error("psmp_paper_sense_ctrl: TRAVEL_W must be 1 to 16");
        end
    endgenerate

    // ============================================================
    // Registers
    psmp_pd_cfg_t          pd_cfg_ff;
    psmp_gp_cfg_t          gp_cfg_ff;
    logic [TRAVEL_W-1:0]   travel_cfg_ff;
    logic [7:0]            cmd_ff;
    logic [3:0]            irq_stat_ff;
    logic [3:0]            irq_mask_ff;
    logic [2:0]            state_ff;
    logic [TRAVEL_W-1:0]   trv_cnt_ff;
    psmp_trv_state_t       trv_state_ff;
    logic [31:0]           rdata_ff;
    logic                  gpio_out_ff;

    logic [2:0]            nxt_state;
    logic [7:0]            nxt_cmd;
    logic [TRAVEL_W-1:0]   nxt_trv_cnt;
    psmp_trv_state_t       nxt_trv_state;
    logic [3:0]            nxt_irq_stat;
    psmp_gp_cfg_t          nxt_gp_cfg;
    logic                  nxt_gpio_out;

    // ============================================================
    // Address decode
    wire wr_travel   = bus_req_in.wr && (bus_req_in.addr == `PSMP_ADDR_TRAVEL);
    wire wr_pd_cfg   = bus_req_in.wr && (bus_req_in.addr == `PSMP_ADDR_PD_CFG);
    wire wr_gp_cfg   = bus_req_in.wr && (bus_req_in.addr == `PSMP_ADDR_GP_CFG);
    wire wr_cmd      = bus_req_in.wr && (bus_req_in.addr == `PSMP_ADDR_CMD);
    wire wr_irq_stat = bus_req_in.wr && (bus_req_in.addr == `PSMP_ADDR_IRQ_STAT);
    wire wr_irq_mask = bus_req_in.wr && (bus_req_in.addr == `PSMP_ADDR_IRQ_MASK);
    wire rd_status   = bus_req_in.rd && (bus_req_in.addr == `PSMP_ADDR_STATUS);

    // ============================================================
    // Input conditioning
    logic [2:0] true_lvl;
    logic [2:0] rise;
    wire  [2:0] pol_vec = {gp_cfg_ff.pol, pd_cfg_ff.pol_b, pd_cfg_ff.pol_a};

    psmp_in_cond #(
        .N           (3),
        .SYNC_STAGES (SYNC_STAGES)
    ) u_in_cond (
        .ref_clk_in (ref_clk_in),
        .sys_rst_in (sys_rst_in),
        .pin_in     ({gpio_pin_in, paper_detect_in_b, paper_detect_in_a}),
        .pol_in     (pol_vec),
        .true_out   (true_lvl),
        .rise_out   (rise)
    );

    wire gp_is_input = !gp_cfg_ff.dir;
    wire gp_rise     = rise[2] && gp_is_input;

    // ============================================================
    // State bits: level mode follows, edge mode latches until read; the general pin bit shows out_state while the pin is an output.
    function automatic logic state_next(input logic cur, input logic edge_mode,
                                        input logic true_now, input logic rd_clr);
        logic held;
        held = cur && !rd_clr;
        state_next = edge_mode ? (held || true_now) : true_now;
    endfunction

    assign nxt_state[`PSMP_ST_PD_A] = state_next(state_ff[0], pd_cfg_ff.edge_a, true_lvl[0], rd_status);
    assign nxt_state[`PSMP_ST_PD_B] = state_next(state_ff[1], pd_cfg_ff.edge_b, true_lvl[1], rd_status);
    assign nxt_state[`PSMP_ST_GPIO] = gp_is_input ?
                                      state_next(state_ff[2], gp_cfg_ff.edge_mode, true_lvl[2], rd_status) :
                                      gp_cfg_ff.out_state;

    // ============================================================
    // Scan stop and post-trip travel
    wire scanning   = cmd_ff[`PSMP_CMD_SCAN_BIT];
    wire trip_a     = rise[0] && pd_cfg_ff.stop_a;
    wire trip_b     = rise[1] && pd_cfg_ff.stop_b;
    wire trv_waits  = (trv_state_ff == PSMP_TRV_WAIT);
    wire trv_done   = trv_waits && (trv_cnt_ff == '0);
    wire halt_now   = scanning && (trip_a || trv_done);

    always_comb begin
        nxt_trv_state = trv_state_ff;
        nxt_trv_cnt   = trv_cnt_ff;
        case (trv_state_ff)
            PSMP_TRV_IDLE: begin
                if (scanning && trip_b) begin
                    nxt_trv_state = PSMP_TRV_WAIT;
                    nxt_trv_cnt   = travel_cfg_ff;
                end
            end
            PSMP_TRV_WAIT: begin
                if (!scanning || trv_done || trip_a) begin
                    nxt_trv_state = PSMP_TRV_IDLE;
                end else if (full_step_in) begin
                    nxt_trv_cnt = trv_cnt_ff - 1'b1;
                end
            end
            default: begin
                nxt_trv_state = PSMP_TRV_IDLE;
            end
        endcase
    end

    // A sensor halt wins over a command write in the same cycle.
    assign nxt_cmd = halt_now ? 8'h00 :
                     wr_cmd   ? bus_req_in.wdata[7:0] : cmd_ff;

    // ============================================================
    // Interrupt events; a new event wins over a write-one clear.
    wire [3:0] ev_vec;
    assign ev_vec[`PSMP_EV_PD_A] = rise[0];
    assign ev_vec[`PSMP_EV_PD_B] = rise[1];
    assign ev_vec[`PSMP_EV_GPIO] = gp_rise;
    assign ev_vec[`PSMP_EV_HALT] = halt_now;
    wire [3:0] w1c_vec = wr_irq_stat ? bus_req_in.wdata[3:0] : 4'h0;
    assign nxt_irq_stat = (irq_stat_ff & ~w1c_vec) | ev_vec;

    // ============================================================
    // Read data
    wire [31:0] status_word = {27'h000_0000, trv_waits, scanning, state_ff};
    wire [31:0] rd_mux =
        (bus_req_in.addr == `PSMP_ADDR_TRAVEL)   ? {{(32-TRAVEL_W){1'b0}}, travel_cfg_ff} :
        (bus_req_in.addr == `PSMP_ADDR_PD_CFG)   ? {24'h00_0000, pd_cfg_ff & 8'h3F} :
        (bus_req_in.addr == `PSMP_ADDR_GP_CFG)   ? {28'h000_0000, gp_cfg_ff} :
        (bus_req_in.addr == `PSMP_ADDR_STATUS)   ? status_word :
        (bus_req_in.addr == `PSMP_ADDR_CMD)      ? {24'h00_0000, cmd_ff} :
        (bus_req_in.addr == `PSMP_ADDR_IRQ_STAT) ? {28'h000_0000, irq_stat_ff} :
        (bus_req_in.addr == `PSMP_ADDR_IRQ_MASK) ? {28'h000_0000, irq_mask_ff} :
        32'h0000_0000;

    // ============================================================
    // Configuration registers; suspend returns the pin to input.
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            pd_cfg_ff     <= psmp_pd_cfg_t'(`PSMP_RST_PD_CFG);
            travel_cfg_ff <= '0;
            irq_mask_ff   <= `PSMP_RST_IRQ;
        end else begin
            if (wr_pd_cfg) begin
                pd_cfg_ff <= psmp_pd_cfg_t'(bus_req_in.wdata[7:0] & 8'h3F);
            end
            if (wr_travel) begin
                travel_cfg_ff <= bus_req_in.wdata[TRAVEL_W-1:0];
            end
            if (wr_irq_mask) begin
                irq_mask_ff <= bus_req_in.wdata[3:0];
            end
        end
    end

    // The drive flop is loaded from the next setting, so pin and enable change on the same edge.
    assign nxt_gp_cfg   = bus_suspend_in ? psmp_gp_cfg_t'(`PSMP_RST_GP_CFG) :
                          wr_gp_cfg      ? psmp_gp_cfg_t'(bus_req_in.wdata[3:0]) : gp_cfg_ff;
    assign nxt_gpio_out = nxt_gp_cfg.out_state && nxt_gp_cfg.dir;

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            gp_cfg_ff <= psmp_gp_cfg_t'(`PSMP_RST_GP_CFG);
        end else begin
            gp_cfg_ff <= nxt_gp_cfg;
        end
    end

    // ============================================================
    // Block state
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            cmd_ff       <= `PSMP_RST_CMD;
            state_ff     <= 3'h0;
            trv_state_ff <= PSMP_TRV_IDLE;
            trv_cnt_ff   <= '0;
            irq_stat_ff  <= `PSMP_RST_IRQ;
        end else begin
            cmd_ff       <= nxt_cmd;
            state_ff     <= nxt_state;
            trv_state_ff <= nxt_trv_state;
            trv_cnt_ff   <= nxt_trv_cnt;
            irq_stat_ff  <= nxt_irq_stat;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            rdata_ff    <= 32'h0000_0000;
            gpio_out_ff <= 1'b0;
        end else begin
            rdata_ff    <= bus_req_in.rd ? rd_mux : 32'h0000_0000;
            gpio_out_ff <= nxt_gpio_out;
        end
    end

    // ============================================================
    // Outputs
    assign gpio_pin_out    = gpio_out_ff;
    assign gpio_pin_oe_out = gp_cfg_ff.dir;
    assign bus_rdata_out   = rdata_ff;
    assign scan_active_out = scanning;
    assign irq_out         = |(irq_stat_ff & irq_mask_ff);

    // ============================================================
    // Assertions
    property p_stop_a;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (scanning && rise[0] && pd_cfg_ff.stop_a) |=> !scanning;
    endproperty
    a_stop_a: assert property (p_stop_a) else $error("detect A trip did not stop scan");

    property p_no_stop;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (scanning && !pd_cfg_ff.stop_a && !trv_waits && !pd_cfg_ff.stop_b && !wr_cmd) |=> scanning;
    endproperty
    a_no_stop: assert property (p_no_stop) else $error("scan stopped with stop bits clear");

    property p_travel_end;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (trv_waits && trv_cnt_ff == '0 && scanning) |=> !scanning && trv_state_ff == PSMP_TRV_IDLE;
    endproperty
    a_travel_end: assert property (p_travel_end) else $error("scan not stopped at end of travel");

    property p_travel_hold;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (trv_waits && trv_cnt_ff != '0 && scanning && !full_step_in && !trip_a && !wr_cmd)
            |=> scanning && $stable(trv_cnt_ff);
    endproperty
    a_travel_hold: assert property (p_travel_hold) else $error("travel advanced without a full step");

    property p_trip_b_load;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (!trv_waits && scanning && trip_b && !trip_a) |=> trv_waits && trv_cnt_ff == $past(travel_cfg_ff);
    endproperty
    a_trip_b_load: assert property (p_trip_b_load) else $error("detect B trip did not load travel");

    property p_level_a;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        !pd_cfg_ff.edge_a |=> state_ff[0] == $past(true_lvl[0]);
    endproperty
    a_level_a: assert property (p_level_a) else $error("detect A level state wrong");

    property p_edge_b_hold;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (pd_cfg_ff.edge_b && state_ff[1] && !rd_status) |=> state_ff[1];
    endproperty
    a_edge_b_hold: assert property (p_edge_b_hold) else $error("detect B latched state lost");

    property p_read_clear;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (rd_status && pd_cfg_ff.edge_a && !true_lvl[0]) |=> !state_ff[0];
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("status read did not clear latch");

    property p_gpio_level;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (gp_is_input && !gp_cfg_ff.edge_mode) |=> state_ff[2] == $past(true_lvl[2]);
    endproperty
    a_gpio_level: assert property (p_gpio_level) else $error("general pin level state wrong");

    property p_suspend_input;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        bus_suspend_in |=> !gpio_pin_oe_out && !gpio_pin_out;
    endproperty
    a_suspend_input: assert property (p_suspend_input) else $error("pin not input after suspend");

    property p_edge_a_hold;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (pd_cfg_ff.edge_a && state_ff[0] && !rd_status) |=> state_ff[0];
    endproperty
    a_edge_a_hold: assert property (p_edge_a_hold) else $error("detect A latched state lost");

    property p_level_b;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        !pd_cfg_ff.edge_b |=> state_ff[1] == $past(true_lvl[1]);
    endproperty
    a_level_b: assert property (p_level_b) else $error("detect B level state wrong");

    property p_gpio_edge;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (gp_is_input && gp_cfg_ff.edge_mode && rise[2]) |=> state_ff[2];
    endproperty
    a_gpio_edge: assert property (p_gpio_edge) else $error("general pin edge not latched");

    property p_gpio_drive;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        gpio_pin_out == (gp_cfg_ff.out_state && gp_cfg_ff.dir);
    endproperty
    a_gpio_drive: assert property (p_gpio_drive) else $error("general pin drive wrong");

    property p_stop_b_off;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (!pd_cfg_ff.stop_b && !trv_waits) |=> !trv_waits;
    endproperty
    a_stop_b_off: assert property (p_stop_b_off) else $error("travel started with stop bit clear");

endmodule

// file: src/psmp_params.svh
`ifndef PSMP_PARAMS_SVH
`define PSMP_PARAMS_SVH

// ============================================================
// Register byte addresses
`define PSMP_ADDR_TRAVEL     8'h4C
`define PSMP_ADDR_PD_CFG     8'h58
`define PSMP_ADDR_GP_CFG     8'h5C
`define PSMP_ADDR_STATUS     8'h60
`define PSMP_ADDR_CMD        8'h64
`define PSMP_ADDR_IRQ_STAT   8'h68
`define PSMP_ADDR_IRQ_MASK   8'h6C

// ============================================================
// Reset values
`define PSMP_RST_PD_CFG      8'h00
`define PSMP_RST_GP_CFG      4'h0
`define PSMP_RST_CMD         8'h00
`define PSMP_RST_IRQ         4'h0

// ============================================================
// Status register bit positions
`define PSMP_ST_PD_A         0
`define PSMP_ST_PD_B         1
`define PSMP_ST_GPIO         2
`define PSMP_ST_SCAN         3
`define PSMP_ST_TRAVEL       4

// ============================================================
// Event bit positions of the interrupt status and mask registers
`define PSMP_EV_PD_A         0
`define PSMP_EV_PD_B         1
`define PSMP_EV_GPIO         2
`define PSMP_EV_HALT         3

// ============================================================
// Command register
`define PSMP_CMD_SCAN_BIT    0

`endif

// file: src/psmp_pkg.sv
package psmp_pkg;

    // ============================================================
    // Register bus request, one cycle per access.
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } psmp_bus_req_t;

    // ============================================================
    // Paper detect configuration, bit 0 at pol_a.
    typedef struct packed {
        logic [1:0] rsvd;
        logic       stop_b;
        logic       edge_b;
        logic       pol_b;
        logic       stop_a;
        logic       edge_a;
        logic       pol_a;
    } psmp_pd_cfg_t;

    // ============================================================
    // General pin configuration, bit 0 at dir.
    typedef struct packed {
        logic out_state;
        logic edge_mode;
        logic pol;
        logic dir;
    } psmp_gp_cfg_t;

    // ============================================================
    // Post-trip travel sequencer states.
    typedef enum logic [1:0] {
        PSMP_TRV_IDLE = 2'b01,
        PSMP_TRV_WAIT = 2'b10
    } psmp_trv_state_t;

endpackage

// file: src/psmp_in_cond.sv
// ============================================================
// Synchroniser, polarity and false-to-true detection for N inputs.
module psmp_in_cond #(
    parameter int N           = 3,
    parameter int SYNC_STAGES = 2
) (
    // Clock and reset
    input  wire logic         ref_clk_in,
    input  wire logic         sys_rst_in,
    // Raw pins and polarity (1: high is true)
    input  wire logic [N-1:0] pin_in,
    input  wire logic [N-1:0] pol_in,
    // Conditioned outputs
    output logic      [N-1:0] true_out,
    output logic      [N-1:0] rise_out
);

    logic [N-1:0] sync_ff [SYNC_STAGES];
    logic [N-1:0] true_ff;
    logic [N-1:0] prev_ff;

    generate
        if (N < 1 || SYNC_STAGES < 2) begin : g_chk
            $error("psmp_in_cond: N must be at least 1 and SYNC_STAGES at least 2");
        end
    endgenerate

    // The first stage feeds only the next stage.
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            for (int i = 0; i < SYNC_STAGES; i++) begin
                sync_ff[i] <= '0;
            end
            true_ff <= '0;
            prev_ff <= '0;
        end else begin
            sync_ff[0] <= pin_in;
            for (int i = 1; i < SYNC_STAGES; i++) begin
                sync_ff[i] <= sync_ff[i-1];
            end
            true_ff <= ~(sync_ff[SYNC_STAGES-1] ^ pol_in);
            prev_ff <= true_ff;
        end
    end

    assign true_out = true_ff;
    assign rise_out = true_ff & ~prev_ff;

    property p_one_rise;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        rise_out[0] |=> !rise_out[0];
    endproperty
    a_one_rise: assert property (p_one_rise) else $error("input event lasted more than one cycle");

endmodule

// file: dv/psmp_sensor_model.sv
// ============================================================
// Paper switches, motor step source and the board side of the general pin.
module psmp_sensor_model #(
    parameter int STEP_GAP = 5
) (
    // Clock
    input  wire logic ref_clk_in,
    // Bench controls
    input  wire logic level_a_in,
    input  wire logic level_b_in,
    input  wire logic gpio_ext_in,
    input  wire logic step_go_in,
    // Design side of the general pin
    input  wire logic drv_pin_in,
    input  wire logic drv_oe_in,
    // Toward the design
    output logic      paper_a_out,
    output logic      paper_b_out,
    output logic      gpio_wire_out,
    output logic      full_step_out
);
    int unsigned gap_cnt_ff = 0;

    // A step request is answered only after STEP_GAP cycles, like a slow motor.
    always_ff @(posedge ref_clk_in) begin
        paper_a_out   <= level_a_in;
        paper_b_out   <= level_b_in;
        full_step_out <= (gap_cnt_ff == 1) && !step_go_in;
        if (step_go_in) begin
            gap_cnt_ff <= STEP_GAP;
        end else if (gap_cnt_ff != 0) begin
            gap_cnt_ff <= gap_cnt_ff - 1;
        end
    end

    // The board lets go of the pin while the design drives it.
    assign gpio_wire_out = drv_oe_in ? drv_pin_in : gpio_ext_in;
endmodule

// file: dv/psmp_paper_sense_ctrl_tb.sv
`include "psmp_params.svh"

module psmp_paper_sense_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import psmp_pkg::*;

    localparam int GAP = 5;

    logic          ref_clk_in = 1'h0;
    logic          sys_rst_in;
    psmp_bus_req_t bus_req;
    logic [31:0]   rdata;
    logic          lvl_a, lvl_b, gp_ext, step_go, suspend;
    logic          pd_a, pd_b, gp_wire, full_step;
    logic          gp_out, gp_oe, scan, irq;
    int            fails = 0;
    int            tests_run = 0;

    always #4 ref_clk_in = ~ref_clk_in;

    psmp_paper_sense_ctrl psmp_paper_sense_ctrl_inst (
        .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .bus_req_in(bus_req), .bus_rdata_out(rdata),
        .paper_detect_in_a(pd_a), .paper_detect_in_b(pd_b), .gpio_pin_in(gp_wire), .gpio_pin_out(gp_out),
        .gpio_pin_oe_out(gp_oe), .bus_suspend_in(suspend), .full_step_in(full_step),
        .scan_active_out(scan), .irq_out(irq));

    psmp_sensor_model #(.STEP_GAP(GAP)) psmp_sensor_model_inst (
        .ref_clk_in(ref_clk_in), .level_a_in(lvl_a), .level_b_in(lvl_b), .gpio_ext_in(gp_ext),
        .step_go_in(step_go), .drv_pin_in(gp_out), .drv_oe_in(gp_oe), .paper_a_out(pd_a),
        .paper_b_out(pd_b), .gpio_wire_out(gp_wire), .full_step_out(full_step));

    // ============================================================
    // Bus cycles and comparisons
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_in);
        bus_req <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
        @(posedge ref_clk_in);
        bus_req.wr <= 1'h0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk_in);
        bus_req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'h0, rd: 1'h1};
        @(posedge ref_clk_in);
        bus_req.rd <= 1'h0;
        #1 d = rdata;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s: expected %h, seen %h", name, exp, got);
        end
    endtask

    task automatic chk_rd(input string name, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        chk(name, exp, d);
    endtask

    // Pins pass the model, the synchroniser and the status stage before they show.
    task automatic set_pins(input logic a, input logic b, input logic g);
        @(posedge ref_clk_in);
        lvl_a  <= a;
        lvl_b  <= b;
        gp_ext <= g;
        repeat (8) @(posedge ref_clk_in);
        #1;
    endtask

    task automatic step;
        @(posedge ref_clk_in);
        step_go <= 1'h1;
        @(posedge ref_clk_in);
        step_go <= 1'h0;
        repeat (GAP + 3) @(posedge ref_clk_in);
        #1;
    endtask

    task automatic wrap_up;
        if (fails == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ============================================================
    // Scenarios
    task automatic t_reset;
        chk("oe", 32'h0000_0000, 32'(gp_oe));
        chk("scan", 32'h0000_0000, 32'(scan));
        chk("irq", 32'h0000_0000, 32'(irq));
        chk_rd("gp_cfg", `PSMP_ADDR_GP_CFG, 32'h0000_0000);
        chk_rd("cmd", `PSMP_ADDR_CMD, 32'h0000_0000);
        wr(`PSMP_ADDR_PD_CFG, 32'h0000_00FF);
        chk_rd("pd_cfg", `PSMP_ADDR_PD_CFG, 32'h0000_003F);
        wr(`PSMP_ADDR_TRAVEL, 32'h0000_FFFF);
        chk_rd("travel", `PSMP_ADDR_TRAVEL, 32'h0000_0FFF);
        wr(8'h70, 32'hFFFF_FFFF);
        chk_rd("unmapped", 8'h70, 32'h0000_0000);
    endtask

    task automatic t_level;
        for (int p = 0; p < 2; p++) begin
            for (int l = 0; l < 2; l++) begin
                wr(`PSMP_ADDR_PD_CFG, (p != 0) ? 32'h0000_0009 : 32'h0000_0000);
                wr(`PSMP_ADDR_GP_CFG, (p != 0) ? 32'h0000_0002 : 32'h0000_0000);
                set_pins(l[0], l[0], l[0]);
                chk_rd("status", `PSMP_ADDR_STATUS, (l == p) ? 32'h0000_0007 : 32'h0000_0000);
            end
        end
    endtask

    task automatic t_edge;
        logic [31:0] d;
        wr(`PSMP_ADDR_PD_CFG, 32'h0000_001B);
        wr(`PSMP_ADDR_GP_CFG, 32'h0000_0006);
        set_pins(1'h0, 1'h0, 1'h0);
        rd(`PSMP_ADDR_STATUS, d);
        wr(`PSMP_ADDR_IRQ_STAT, 32'h0000_000F);
        wr(`PSMP_ADDR_IRQ_MASK, 32'h0000_0007);
        set_pins(1'h1, 1'h1, 1'h1);
        set_pins(1'h0, 1'h0, 1'h0);
        chk("irq", 32'h0000_0001, 32'(irq));
        chk_rd("irq_stat", `PSMP_ADDR_IRQ_STAT, 32'h0000_0007);
        chk_rd("status latched", `PSMP_ADDR_STATUS, 32'h0000_0007);
        chk_rd("status cleared", `PSMP_ADDR_STATUS, 32'h0000_0000);
        set_pins(1'h1, 1'h1, 1'h1);
        rd(`PSMP_ADDR_STATUS, d);
        chk_rd("status held", `PSMP_ADDR_STATUS, 32'h0000_0007);
        wr(`PSMP_ADDR_IRQ_MASK, 32'h0000_0000);
        repeat (2) @(posedge ref_clk_in);
        #1 chk("irq masked", 32'h0000_0000, 32'(irq));
        wr(`PSMP_ADDR_IRQ_STAT, 32'h0000_0007);
        chk_rd("irq_stat clr", `PSMP_ADDR_IRQ_STAT, 32'h0000_0000);
        set_pins(1'h0, 1'h0, 1'h0);
    endtask

    task automatic t_stop_a;
        wr(`PSMP_ADDR_PD_CFG, 32'h0000_0009);
        wr(`PSMP_ADDR_CMD, 32'h0000_0001);
        set_pins(1'h1, 1'h0, 1'h0);
        chk("scan kept", 32'h0000_0001, 32'(scan));
        set_pins(1'h0, 1'h0, 1'h0);
        wr(`PSMP_ADDR_PD_CFG, 32'h0000_000D);
        set_pins(1'h1, 1'h0, 1'h0);
        chk("scan halted", 32'h0000_0000, 32'(scan));
        chk_rd("cmd", `PSMP_ADDR_CMD, 32'h0000_0000);
        chk_rd("irq_stat", `PSMP_ADDR_IRQ_STAT, 32'h0000_0009);
        wr(`PSMP_ADDR_IRQ_STAT, 32'h0000_000F);
        set_pins(1'h0, 1'h0, 1'h0);
    endtask

    task automatic t_stop_b;
        wr(`PSMP_ADDR_PD_CFG, 32'h0000_0008);
        wr(`PSMP_ADDR_CMD, 32'h0000_0001);
        set_pins(1'h0, 1'h1, 1'h0);
        chk("scan kept", 32'h0000_0001, 32'(scan));
        set_pins(1'h0, 1'h0, 1'h0);
        wr(`PSMP_ADDR_PD_CFG, 32'h0000_0028);
        for (int n = 0; n < 3; n += 2) begin
            wr(`PSMP_ADDR_TRAVEL, 32'(n));
            wr(`PSMP_ADDR_CMD, 32'h0000_0001);
            set_pins(1'h0, 1'h1, 1'h0);
            for (int i = 0; i < n; i++) begin
                chk("scan travel", 32'h0000_0001, 32'(scan));
                step();
            end
            chk("scan stopped", 32'h0000_0000, 32'(scan));
            set_pins(1'h0, 1'h0, 1'h0);
        end
    endtask

    task automatic t_gpio_out;
        wr(`PSMP_ADDR_GP_CFG, 32'h0000_0009);
        #1 chk("oe", 32'h0000_0001, 32'(gp_oe));
        chk("pin high", 32'h0000_0001, 32'(gp_out));
        wr(`PSMP_ADDR_GP_CFG, 32'h0000_0001);
        #1 chk("pin low", 32'h0000_0000, 32'(gp_out));
        wr(`PSMP_ADDR_GP_CFG, 32'h0000_0009);
        suspend <= 1'h1;
        @(posedge ref_clk_in);
        suspend <= 1'h0;
        #1 chk("oe suspend", 32'h0000_0000, 32'(gp_oe));
        chk_rd("gp_cfg", `PSMP_ADDR_GP_CFG, 32'h0000_0000);
    endtask

    // ============================================================
    // Main sequence and watchdog
    initial begin
        bus_req    = '0;
        lvl_a      = 1'h0;
        lvl_b      = 1'h0;
        gp_ext     = 1'h0;
        step_go    = 1'h0;
        suspend    = 1'h0;
        sys_rst_in = 1'h1;
        repeat (8) @(posedge ref_clk_in);
        sys_rst_in <= 1'h0;
        @(posedge ref_clk_in);
        #1;
        t_reset();
        t_level();
        t_edge();
        t_stop_a();
        t_stop_b();
        t_gpio_out();
        wrap_up();
    end

    initial begin
        repeat (20000) @(posedge ref_clk_in);
        fails++;
        wrap_up();
    end
endmodule
